// ===== atten_pkg.sv
package atten_pkg;
   localparam int SHIFT_LEN = 8;
   localparam int CTRL_BITS = 5;
   localparam int SER_DELAY = 8;
   // positions of the five control bits inside the shift register, lsb first
   localparam int POS_HALF = 0;
   localparam int POS_ONE = 1;
   localparam int POS_TWO = 2;
   localparam int POS_FOUR = 3;
   localparam int POS_EIGHT = 4;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   // control lines are active low: all high is minimum loss
   localparam logic [4:0] CTRL_RESET_N = 5'h1F;

   typedef struct packed {
      logic data;
      logic sclk;
      logic latch;
      logic clear_n;
   } pins_s;
endpackage

// ===== edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // asynchronous pin and its synchronised view
   input wire logic pin_in,
   output logic level,
   output logic rise
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic last_reg, last_next;

   always_comb begin
      meta_next = pin_in;
      sync_next = meta_reg;
      last_next = sync_reg;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
endmodule

// ===== serial_attenuator_control.sv
`timescale 1ns/1ps
// Contract
// - While clear_n is low the shift register is held at zero regardless of clock and latch.
// - With clear_n high each rising shift clock shifts the register one place, taking serial in.
// - The first bit shifted in is the least significant bit of the control word.
// - With clear_n high a rising latch copies the register onto the control lines, held until next.
// - Serial out repeats serial in delayed by exactly eight shift-clock cycles.
// - Each attenuation state is chosen by an eight-bit word shifted in before latching; its first five bits are used.
// - Control bits weigh 0.5, 1, 2, 4 and 8 dB, the 0.5 dB bit least significant.
// - Control lines are active low: all high is minimum loss, all low is 15.5 dB.
// - Several low bits give the sum of their weights.
module serial_attenuator_control #(
   parameter int SHIFT_LEN = atten_pkg::SHIFT_LEN
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial control pins from the controller
   input wire atten_pkg::pins_s pins,
   // chained serial output
   output logic ser_out,
   // active-low attenuation lines: half, one, two, four, eight dB
   output logic [atten_pkg::CTRL_BITS-1:0] ctrl_n,
   // shift register contents for observation
   output logic [SHIFT_LEN-1:0] shift_state
);
   logic data_lvl, clr_lvl, sclk_rise, latch_rise;
   logic [SHIFT_LEN-1:0] shift_reg, shift_next;
   logic [atten_pkg::CTRL_BITS-1:0] ctrl_n_reg, ctrl_n_next;
   logic ser_reg, ser_next;

   edge_sync u_data (.clk(clk), .reset(reset), .pin_in(pins.data), .level(data_lvl), .rise());
   edge_sync u_sclk (.clk(clk), .reset(reset), .pin_in(pins.sclk), .level(), .rise(sclk_rise));
   edge_sync u_latch (.clk(clk), .reset(reset), .pin_in(pins.latch), .level(),
      .rise(latch_rise));
   edge_sync u_clr (.clk(clk), .reset(reset), .pin_in(pins.clear_n), .level(clr_lvl), .rise());

   // pick the five weighted bits out of the shifted word
   function automatic logic [atten_pkg::CTRL_BITS-1:0] pick_ctrl(input logic [SHIFT_LEN-1:0] w);
      pick_ctrl = {w[atten_pkg::POS_EIGHT], w[atten_pkg::POS_FOUR], w[atten_pkg::POS_TWO],
         w[atten_pkg::POS_ONE], w[atten_pkg::POS_HALF]};
   endfunction

   always_comb begin
      shift_next = shift_reg;
      ctrl_n_next = ctrl_n_reg;
      ser_next = ser_reg;
      if (!clr_lvl) begin
         shift_next = '0;
      end else begin
         if (sclk_rise) begin
            // new bits enter the top, so the first bit ends at bit 0
            shift_next = {data_lvl, shift_reg[SHIFT_LEN-1:1]};
            ser_next = shift_reg[0];
         end
         if (latch_rise) begin
            ctrl_n_next = pick_ctrl(shift_reg);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shift_reg <= '0;
         ctrl_n_reg <= atten_pkg::CTRL_RESET_N;
         ser_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         ctrl_n_reg <= ctrl_n_next;
         ser_reg <= ser_next;
      end
   end

   assign ctrl_n = ctrl_n_reg;
   assign ser_out = ser_reg;
   assign shift_state = shift_reg;

   // checker-only state, kept apart from the datapath so the checks below
   // compare the register against a second, independent model of the link
   // shifts seen since the last clear, saturating at the register length
   logic [3:0] shifts_reg, shifts_next;
   // serial input history, newest bit at the top, oldest at bit 0
   logic [atten_pkg::SER_DELAY-1:0] hist_reg, hist_next;

   always_comb begin
      shifts_next = shifts_reg;
      hist_next = hist_reg;
      if (!clr_lvl) begin
         shifts_next = 4'h0;
         hist_next = '0;
      end else if (sclk_rise) begin
         hist_next = {data_lvl, hist_reg[atten_pkg::SER_DELAY-1:1]};
         // saturate so a long stream never wraps the count
         if (shifts_reg != 4'(SHIFT_LEN)) begin
            shifts_next = shifts_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         shifts_reg <= 4'h0;
         hist_reg <= '0;
      end else begin
         shifts_reg <= shifts_next;
         hist_reg <= hist_next;
      end
   end

   chk_clear_holds: assert property (@(posedge clk) disable iff (reset)
      !clr_lvl |=> shift_reg == '0) else $error("shift register not cleared");
   chk_shift_step: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && sclk_rise |=> shift_reg[SHIFT_LEN-2:0] == $past(shift_reg[SHIFT_LEN-1:1]))
      else $error("shift did not advance");
   chk_shift_in: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && sclk_rise |=> shift_reg[SHIFT_LEN-1] == $past(data_lvl))
      else $error("serial input not sampled");
   chk_latch_copy: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n == pick_ctrl($past(shift_reg)))
      else $error("latch did not copy");
   chk_ctrl_hold: assert property (@(posedge clk) disable iff (reset)
      !(clr_lvl && latch_rise) |=> $stable(ctrl_n)) else $error("control lines moved");
   chk_ser_delay: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && sclk_rise |=> ser_out == $past(shift_reg[0]))
      else $error("serial out wrong");
   chk_half_bit: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n[0] == $past(shift_reg[atten_pkg::POS_HALF]))
      else $error("lsb weight misplaced");
   chk_eight_bit: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n[4] == $past(shift_reg[atten_pkg::POS_EIGHT]))
      else $error("msb weight misplaced");

   // clear must not disturb what is already on the control lines
   chk_clear_keeps_ctrl: assert property (@(posedge clk) disable iff (reset)
      !clr_lvl |=> $stable(ctrl_n))
      else $error("clear moved control lines");
   // with clear_n high, no shift clock edge, no movement of the register
   chk_shift_hold: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && !sclk_rise |=> $stable(shift_reg))
      else $error("shift register moved without clock");
   // the register must match the independent history model at all times
   chk_word_order: assert property (@(posedge clk) disable iff (reset)
      shift_reg == hist_reg)
      else $error("bit order differs from history");
   // serial out changes only on a shift clock edge
   chk_ser_hold: assert property (@(posedge clk) disable iff (reset)
      !(clr_lvl && sclk_rise) |=> $stable(ser_out))
      else $error("serial out moved without clock");
   // once eight bits have passed, serial out is the input from eight shifts back
   chk_ser_history: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && sclk_rise && shifts_reg == 4'(SHIFT_LEN) |=> ser_out == $past(hist_reg[0]))
      else $error("serial out not eight shifts late");
   // a latch after a full word presents that word's control bits
   chk_full_word: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise && shifts_reg == 4'(SHIFT_LEN)
      |=> ctrl_n == pick_ctrl($past(hist_reg)))
      else $error("full word not latched");
   chk_one_bit: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n[1] == $past(shift_reg[atten_pkg::POS_ONE]))
      else $error("one dB weight misplaced");
   chk_two_bit: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n[2] == $past(shift_reg[atten_pkg::POS_TWO]))
      else $error("two dB weight misplaced");
   chk_four_bit: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n[3] == $past(shift_reg[atten_pkg::POS_FOUR]))
      else $error("four dB weight misplaced");
   // reset leaves the lines all high, the minimum-loss state
   chk_reset_lines: assert property (@(posedge clk)
      reset |=> ctrl_n == atten_pkg::CTRL_RESET_N && ser_out == 1'b0)
      else $error("reset state wrong");
   // an all-ones word selects minimum loss
   chk_min_loss: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise && pick_ctrl(shift_reg) == atten_pkg::CTRL_RESET_N
      |=> ctrl_n == atten_pkg::CTRL_RESET_N)
      else $error("minimum loss not selected");
   // the three unused positions never reach the lines
   chk_ignored_bits: assert property (@(posedge clk) disable iff (reset)
      clr_lvl && latch_rise |=> ctrl_n == pick_ctrl($past(shift_reg) & 8'h1F))
      else $error("unused bits leaked");
   // the helper count never passes the register length
   chk_count_bound: assert property (@(posedge clk) disable iff (reset)
      shifts_reg <= 4'(SHIFT_LEN))
      else $error("shift count overran");
endmodule

// ===== ctl_model.sv
`timescale 1ns/1ps
module ctl_model (
   // clock and chained input
   input wire logic clk,
   input wire logic ser_out,
   // device pins
   output atten_pkg::pins_s pins
);
   logic [7:0] seen;
   initial pins = 4'h1;
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // lsb first, data held around each rise
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         pins.data <= b[i];
         tick(3);
         pins.sclk <= 1'b1;
         tick(5);
         seen[i] = ser_out;
         pins.sclk <= 1'b0;
      end
      // released data line flips
      pins.data <= ~b[7];
      tick(3);
   endtask
   task automatic strobe();
      pins.latch <= 1'b1;
      tick(5);
      pins.latch <= 1'b0;
      tick(3);
   endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, e, a); end end
module tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ser_out;
   logic [4:0] ctrl_n;
   logic [7:0] shift_state;
   logic [7:0] prev = 8'h00;
   atten_pkg::pins_s pins;
   int n_mismatch = 0;
   int n_compared = 0;
   // each row: shifted word, then the lines it should give (bits 7:5 ignored)
   logic [12:0] rows [8] = '{{8'h1F, 5'h1F}, {8'h1E, 5'h1E}, {8'h1D, 5'h1D}, {8'h1B, 5'h1B},
      {8'h17, 5'h17}, {8'h0F, 5'h0F}, {8'h00, 5'h00}, {8'hE5, 5'h05}};
   serial_attenuator_control u_dut (.clk(clk), .reset(reset), .pins(pins),
      .ser_out(ser_out), .ctrl_n(ctrl_n), .shift_state(shift_state));
   ctl_model u_ctl (.clk(clk), .ser_out(ser_out), .pins(pins));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("ctrl_n", 5'h1F, ctrl_n)
      `CHK("shift", 8'h00, shift_state)
      $display("reset done");
      foreach (rows[i]) begin
         u_ctl.send(rows[i][12:5]);
         `CHK("shift", rows[i][12:5], shift_state)
         `CHK("ser_out", prev, u_ctl.seen)
         u_ctl.strobe();
         `CHK("ctrl_n", rows[i][4:0], ctrl_n)
         prev = rows[i][12:5];
         $display("row %0d done", i);
      end
      // clear ignores shifts and latch, lines kept
      u_ctl.pins.clear_n <= 1'b0;
      u_ctl.send(8'hAA);
      u_ctl.strobe();
      `CHK("shift", 8'h00, shift_state)
      `CHK("ctrl_n", 5'h05, ctrl_n)
      $display("clear done");
      u_ctl.pins.clear_n <= 1'b1;
      u_ctl.tick(4);
      u_ctl.send(8'h03);
      `CHK("shift", 8'h03, shift_state)
      `CHK("ctrl_n", 5'h05, ctrl_n)
      $display("hold done");
      reset <= 1'b1;
      u_ctl.tick(2);
      reset <= 1'b0;
      u_ctl.tick(4);
      `CHK("ctrl_n", 5'h1F, ctrl_n)
      `CHK("shift", 8'h00, shift_state)
      `CHK("ser_out", 1'b0, ser_out)
      $display("mid reset done");
      wrap_up();
   end
endmodule
